// *** design/cpf_pkg.sv ***
// Purpose: shared constants and carriers for the crosspoint power and fault registers
// Assumes: four inputs, four outputs, 2-bit route field per output
// Notes: control word layout mirrors the register bit order, msb first
package cpf_pkg;

   ////////////////////////////////////////////////////////////////////////////////
   // geometry
   localparam int CPF_NUM_PORTS = 4;
   localparam int CPF_SEL_W = 2;
   localparam int CPF_ROUTE_W = CPF_NUM_PORTS * CPF_SEL_W;
   localparam int CPF_REG_W = 8;
   localparam int CPF_SYNC_STAGES = 2;

   ////////////////////////////////////////////////////////////////////////////////
   // register map
   localparam logic [7:0] CPF_ADDR_POWER_CONTROL = 8'h03;
   localparam logic [7:0] CPF_ADDR_INPUT_FAULT_STATUS = 8'h04;

   ////////////////////////////////////////////////////////////////////////////////
   // control word, bit 7 down to bit 0
   typedef struct packed {
      logic soft_power_bit;
      logic open_input_monitor_enable;
      logic [1:0] spare;
      logic [CPF_NUM_PORTS-1:0] output_keep_alive;
   } cpf_ctrl_t;

   // reset: soft power 0, monitor 0, spare 0, keep-alive all ones
   localparam cpf_ctrl_t CPF_CTRL_RESET = '{
      soft_power_bit: 1'b0,
      open_input_monitor_enable: 1'b0,
      spare: 2'h0,
      output_keep_alive: 4'hf
   };

   localparam logic [CPF_ROUTE_W-1:0] CPF_ROUTE_RESET = 8'h00;
   localparam logic [CPF_NUM_PORTS-1:0] CPF_VALID_RESET = 4'h0;

   // word carried across the clock boundary
   typedef struct packed {
      cpf_ctrl_t ctrl;
      logic [CPF_ROUTE_W-1:0] route;
   } cpf_xfer_t;

   // power enables toward the analog blocks
   typedef struct packed {
      logic core_en;
      logic [CPF_NUM_PORTS-1:0] out_en;
      logic [CPF_NUM_PORTS-1:0] in_en;
      logic [CPF_NUM_PORTS-1:0] mon_en;
   } cpf_power_en_t;

   localparam cpf_power_en_t CPF_POWER_EN_RESET = '0;

endpackage

// *** design/cpf_sync.sv ***
// Purpose: two-stage level synchroniser, any width
// Assumes: each bit is an independent slow level
// Notes: only the second stage is visible outside
`timescale 1ns/100ps
module cpf_sync #(
   parameter int WIDTH = 1
) (
   input wire logic clk,
   input wire logic rst,
   input wire logic [WIDTH-1:0] din,
   output logic [WIDTH-1:0] dout
);

   typedef struct packed {
      logic [WIDTH-1:0] stage1;
      logic [WIDTH-1:0] stage2;
   } cpf_sync_state_t;

   cpf_sync_state_t st;
   cpf_sync_state_t next_st;

   ////////////////////////////////////////////////////////////////////////////////
   // shift chain, first stage feeds only the second
   always_comb begin
      next_st = st;
      next_st.stage1 = din;
      next_st.stage2 = st.stage1;
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         st <= '0;
      end else begin
         st <= next_st;
      end
   end

   assign dout = st.stage2;

endmodule

// *** design/cpf_top.sv ***
// Purpose: power control and open-input fault reporting for a 4x4 crosspoint
// Assumes: smbus framing is decoded elsewhere and presents byte accesses on smb_clk
// Notes: registers live on smb_clk; power gating runs on clk_sys
//
// Function
// - keep-alive bits reset one, zero gates output
// - soft power bit resets zero, powers down
// - powered up when pin high or soft bit
// - power-down keeps register access alive, monitors only with monitor enable
// - monitor enable wakes receivers while powered down
// - monitor enable resets zero, overrides input gating
// - powered up, unused inputs and outputs switched off
// - output on when needed and kept alive
// - input on when needed or monitored
// - status bit one means valid, resets zero
// - status upper nibble reserved, read-only
// - control at address 3, status at 4
// - four 2-bit route fields select inputs
`timescale 1ns/100ps
module cpf_top (
   input wire logic clk_sys,
   input wire logic rst,
   input wire logic smb_clk,
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic [7:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic [cpf_pkg::CPF_ROUTE_W-1:0] route_sel,
   input wire logic power_down_pin_n,
   input wire logic [cpf_pkg::CPF_NUM_PORTS-1:0] input_signal_valid,
   output logic [7:0] reg_rdata,
   output logic powered_up,
   output logic core_en,
   output logic [cpf_pkg::CPF_NUM_PORTS-1:0] output_port_en,
   output logic [cpf_pkg::CPF_NUM_PORTS-1:0] input_port_en,
   output logic [cpf_pkg::CPF_NUM_PORTS-1:0] monitor_en
);

   ////////////////////////////////////////////////////////////////////////////////
   // state carriers, one per clock domain

   // smb_clk side: register file, read data, outgoing snapshot
   typedef struct packed {
      cpf_pkg::cpf_ctrl_t ctrl;
      logic [7:0] rdata;
      cpf_pkg::cpf_xfer_t snap;
      logic req_tgl;
   } cpf_link_state_t;

   // clk_sys side: received settings, handshake, enables, fault view
   typedef struct packed {
      cpf_pkg::cpf_xfer_t cfg;
      logic ack_tgl;
      logic powered_up;
      cpf_pkg::cpf_power_en_t en;
      logic [cpf_pkg::CPF_NUM_PORTS-1:0] signal_valid;
   } cpf_sys_state_t;

   cpf_link_state_t lk;
   cpf_link_state_t next_lk;
   cpf_sys_state_t sy;
   cpf_sys_state_t next_sy;

   ////////////////////////////////////////////////////////////////////////////////
   // helpers

   // pick the 2-bit input select of one output
   function automatic logic [cpf_pkg::CPF_SEL_W-1:0] route_field(
      input logic [cpf_pkg::CPF_ROUTE_W-1:0] route,
      input int unsigned port
   );
      route_field = route[port*cpf_pkg::CPF_SEL_W +: cpf_pkg::CPF_SEL_W];
   endfunction

   // address match against one register offset
   function automatic logic addr_hit(
      input logic [7:0] addr,
      input logic [7:0] target
   );
      addr_hit = (addr == target);
   endfunction

   // inputs referenced by at least one enabled output
   function automatic logic [cpf_pkg::CPF_NUM_PORTS-1:0] inputs_needed(
      input logic [cpf_pkg::CPF_ROUTE_W-1:0] route,
      input logic [cpf_pkg::CPF_NUM_PORTS-1:0] outs
   );
      logic [cpf_pkg::CPF_NUM_PORTS-1:0] acc;
      acc = '0;
      for (int unsigned o = 0; o < cpf_pkg::CPF_NUM_PORTS; o++) begin
         for (int unsigned i = 0; i < cpf_pkg::CPF_NUM_PORTS; i++) begin
            if (outs[o] && route_field(route, o) == cpf_pkg::CPF_SEL_W'(i)) begin
               acc[i] = 1'b1;
            end
         end
      end
      inputs_needed = acc;
   endfunction

   ////////////////////////////////////////////////////////////////////////////////
   // crossings

   logic ack_in_link;
   logic req_in_sys;
   logic pin_sync_n;
   logic [cpf_pkg::CPF_NUM_PORTS-1:0] valid_sync;
   logic [cpf_pkg::CPF_NUM_PORTS-1:0] status_in_link;

   // handshake acknowledge back to the register side
   cpf_sync #(
      .WIDTH(1)
   ) u_ack_sync (
      .clk(smb_clk),
      .rst(rst),
      .din(sy.ack_tgl),
      .dout(ack_in_link)
   );

   // handshake request into the power side
   cpf_sync #(
      .WIDTH(1)
   ) u_req_sync (
      .clk(clk_sys),
      .rst(rst),
      .din(lk.req_tgl),
      .dout(req_in_sys)
   );

   // external power-down pin, asynchronous level
   cpf_sync #(
      .WIDTH(1)
   ) u_pin_sync (
      .clk(clk_sys),
      .rst(rst),
      .din(power_down_pin_n),
      .dout(pin_sync_n)
   );

   // monitor comparators, asynchronous levels
   cpf_sync #(
      .WIDTH(cpf_pkg::CPF_NUM_PORTS)
   ) u_valid_sync (
      .clk(clk_sys),
      .rst(rst),
      .din(input_signal_valid),
      .dout(valid_sync)
   );

   // fault view toward the register side, per-bit levels
   cpf_sync #(
      .WIDTH(cpf_pkg::CPF_NUM_PORTS)
   ) u_status_sync (
      .clk(smb_clk),
      .rst(rst),
      .din(sy.signal_valid),
      .dout(status_in_link)
   );

   ////////////////////////////////////////////////////////////////////////////////
   // register side, smb_clk

   // writes, reads and snapshot launch
   always_comb begin
      cpf_pkg::cpf_xfer_t cur;
      cur = '0;
      next_lk = lk;
      cur.ctrl = lk.ctrl;
      cur.route = route_sel;
      // control is the only writable word here
      if (reg_wr && addr_hit(reg_addr, cpf_pkg::CPF_ADDR_POWER_CONTROL)) begin
         next_lk.ctrl = cpf_pkg::cpf_ctrl_t'(reg_wdata);
      end
      // read mux, unmapped reads give zero
      if (reg_rd) begin
         if (addr_hit(reg_addr, cpf_pkg::CPF_ADDR_POWER_CONTROL)) begin
            next_lk.rdata = lk.ctrl;
         end else if (addr_hit(reg_addr, cpf_pkg::CPF_ADDR_INPUT_FAULT_STATUS)) begin
            next_lk.rdata = '0;
            next_lk.rdata[cpf_pkg::CPF_NUM_PORTS-1:0] = status_in_link;
         end else begin
            next_lk.rdata = '0;
         end
      end
      // new snapshot only once the previous one is acknowledged
      if (lk.req_tgl == ack_in_link && cur != lk.snap) begin
         next_lk.snap = cur;
         next_lk.req_tgl = ~lk.req_tgl;
      end
   end

   // register-side state
   always_ff @(posedge smb_clk or posedge rst) begin
      if (rst) begin
         lk.ctrl <= cpf_pkg::CPF_CTRL_RESET;
         lk.rdata <= '0;
         lk.snap.ctrl <= cpf_pkg::CPF_CTRL_RESET;
         lk.snap.route <= cpf_pkg::CPF_ROUTE_RESET;
         lk.req_tgl <= 1'b0;
      end else begin
         lk <= next_lk;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // power side, clk_sys

   // settings capture, mode decision and gating
   always_comb begin
      logic up;
      logic mon;
      logic [cpf_pkg::CPF_NUM_PORTS-1:0] outs;
      logic [cpf_pkg::CPF_NUM_PORTS-1:0] ins;
      up = 1'b0;
      mon = 1'b0;
      outs = '0;
      ins = '0;
      next_sy = sy;
      // take a completed snapshot and acknowledge it
      if (req_in_sys != sy.ack_tgl) begin
         next_sy.cfg = lk.snap;
         next_sy.ack_tgl = req_in_sys;
      end
      // pin high or soft bit set means powered up
      up = pin_sync_n | sy.cfg.ctrl.soft_power_bit;
      mon = sy.cfg.ctrl.open_input_monitor_enable;
      // every output carries a route, so each is needed while up
      if (up) begin
         outs = sy.cfg.ctrl.output_keep_alive;
         ins = inputs_needed(sy.cfg.route, outs);
      end
      // monitor enable forces receivers on in either mode
      if (mon) begin
         ins = '1;
      end
      next_sy.powered_up = up;
      next_sy.en.core_en = up;
      next_sy.en.out_en = outs;
      next_sy.en.in_en = ins;
      next_sy.en.mon_en = ins;
      // a disabled monitor cannot vouch for its input
      next_sy.signal_valid = valid_sync & ins;
   end

   // power-side state
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         sy.cfg.ctrl <= cpf_pkg::CPF_CTRL_RESET;
         sy.cfg.route <= cpf_pkg::CPF_ROUTE_RESET;
         sy.ack_tgl <= 1'b0;
         sy.powered_up <= 1'b0;
         sy.en <= cpf_pkg::CPF_POWER_EN_RESET;
         sy.signal_valid <= cpf_pkg::CPF_VALID_RESET;
      end else begin
         sy <= next_sy;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // outputs, all straight from flip-flops

   assign reg_rdata = lk.rdata;
   assign powered_up = sy.powered_up;
   assign core_en = sy.en.core_en;
   assign output_port_en = sy.en.out_en;
   assign input_port_en = sy.en.in_en;
   assign monitor_en = sy.en.mon_en;

endmodule

// *** tb/cpf_host.sv ***
// Purpose: register host model driving byte accesses on smb_clk
// Assumes: one access at a time, strobes taken on the rising edge
// Notes: released address and data lines show the inverse value
`timescale 1ns/100ps
module cpf_host (
   input wire logic smb_clk,
   output logic reg_wr,
   output logic reg_rd,
   output logic [7:0] reg_addr,
   output logic [7:0] reg_wdata,
   input wire logic [7:0] reg_rdata
);
   // idle bus at time zero
   initial begin
      reg_wr = 1'b0;
      reg_rd = 1'b0;
      reg_addr = 8'h00;
      reg_wdata = 8'h00;
   end

   // one byte write, held up to its taking edge
   task wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge smb_clk);
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge smb_clk);
      reg_wr <= 1'b0;
      reg_addr <= ~a;
      reg_wdata <= ~d;
   endtask

   // one byte read, data taken once settled
   task rd(input logic [7:0] a, output logic [7:0] v);
      @(posedge smb_clk);
      reg_rd <= 1'b1;
      reg_addr <= a;
      @(posedge smb_clk);
      reg_rd <= 1'b0;
      reg_addr <= ~a;
      @(posedge smb_clk);
      @(negedge smb_clk);
      v = reg_rdata;
   endtask
endmodule

// *** tb/cpf_props.sv ***
// Purpose: port checks for the power and fault registers
// Assumes: both domains share the async reset
// Notes: bound to cpf_top below
`timescale 1ns/100ps
module cpf_props (
   input wire logic clk_sys,
   input wire logic rst,
   input wire logic smb_clk,
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic [7:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic power_down_pin_n,
   input wire logic [7:0] reg_rdata,
   input wire logic powered_up,
   input wire logic core_en,
   input wire logic [3:0] output_port_en,
   input wire logic [3:0] input_port_en,
   input wire logic [3:0] monitor_en
);
   ////////////////////////////////////////////////////////////////////////////////
   // power side
   a_core_power:
      assert property (@(posedge clk_sys) disable iff (rst) core_en == powered_up)
         else $error("core enable off power state");
   a_mon_input:
      assert property (@(posedge clk_sys) disable iff (rst) monitor_en == input_port_en)
         else $error("monitor enable differs from input enable");
   a_out_needs_power:
      assert property (@(posedge clk_sys) disable iff (rst) |output_port_en |-> powered_up)
         else $error("output on while powered down");
   a_pin_wakes:
      assert property (@(posedge clk_sys) disable iff (rst)
         power_down_pin_n [*5] |-> powered_up)
         else $error("pin high but not powered");
   a_down_all_inputs:
      assert property (@(posedge clk_sys) disable iff (rst)
         !powered_up && |input_port_en |-> input_port_en == 4'hf)
         else $error("partial inputs while powered down");
   ////////////////////////////////////////////////////////////////////////////////
   // register side
   a_unmapped_zero:
      assert property (@(posedge smb_clk) disable iff (rst)
         reg_rd && reg_addr != 8'h03 && reg_addr != 8'h04 |=> reg_rdata == 8'h00)
         else $error("unmapped read not zero");
   a_status_upper:
      assert property (@(posedge smb_clk) disable iff (rst)
         reg_rd && reg_addr == 8'h04 |=> reg_rdata[7:4] == 4'h0)
         else $error("status upper bits not zero");
   a_ctrl_readback:
      assert property (@(posedge smb_clk) disable iff (rst)
         reg_wr && reg_addr == 8'h03 ##1 !reg_rd ##1 reg_rd && reg_addr == 8'h03
         |=> reg_rdata == $past(reg_wdata, 3))
         else $error("control readback wrong");
   a_rdata_holds:
      assert property (@(posedge smb_clk) disable iff (rst) !reg_rd |=> $stable(reg_rdata))
         else $error("read data moved without read");
endmodule

bind cpf_top cpf_props u_props (.clk_sys, .rst, .smb_clk, .reg_wr, .reg_rd, .reg_addr,
   .reg_wdata, .power_down_pin_n, .reg_rdata, .powered_up, .core_en, .output_port_en,
   .input_port_en, .monitor_en);

// *** tb/tb.sv ***
// Purpose: register and power sequence test of cpf_top
// Assumes: host model owns the register strobes
// Notes: enables polled under a bounded wait
`timescale 1ns/100ps
module tb;
   logic clk_sys = 1'b0;
   logic smb_clk = 1'b0;
   logic rst = 1'b1;
   logic reg_wr, reg_rd, powered_up, core_en;
   logic [7:0] reg_addr, reg_wdata, reg_rdata, rv;
   logic [7:0] route_sel = 8'h00;
   logic power_down_pin_n = 1'b0;
   logic [3:0] input_signal_valid = 4'h0;
   logic [3:0] output_port_en, input_port_en, monitor_en;
   int errors = 0;
   int total_checks = 0;

   // clocks, unrelated phases
   always #10 clk_sys = ~clk_sys;
   always #15 smb_clk = ~smb_clk;

   cpf_top uut (.clk_sys, .rst, .smb_clk, .reg_wr, .reg_rd, .reg_addr, .reg_wdata,
      .route_sel, .power_down_pin_n, .input_signal_valid, .reg_rdata, .powered_up,
      .core_en, .output_port_en, .input_port_en, .monitor_en);
   cpf_host host (.smb_clk, .reg_wr, .reg_rd, .reg_addr, .reg_wdata, .reg_rdata);

   ////////////////////////////////////////////////////////////////////////////////
   // helpers
   task chk(input string nm, input logic [8:0] seen, input logic [8:0] exp);
      total_checks++;
      if (seen !== exp) begin
         errors++;
         $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
      end
   endtask

   task end_sim;
      $display("checks %0d errors %0d", total_checks, errors);
      if (errors == 0 && total_checks > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask

   task exp_en(input logic p, input logic [3:0] o, input logic [3:0] i);
      int n;
      n = 0;
      while ({powered_up, output_port_en, input_port_en} !== {p, o, i} && n < 60) begin
         @(negedge clk_sys);
         n++;
      end
      chk("enables", {powered_up, output_port_en, input_port_en}, {p, o, i});
      chk("core", {8'h00, core_en}, {8'h00, p});
      chk("monitors", {5'h00, monitor_en}, {5'h00, i});
      // a wait that ran out ends the run
      if ({powered_up, output_port_en, input_port_en} !== {p, o, i}) begin
         end_sim();
      end
   endtask

   task rd_chk(input logic [7:0] a, input logic [7:0] e);
      host.rd(a, rv);
      chk("register", {1'b0, rv}, {1'b0, e});
   endtask

   task drive(input logic pin, input logic [7:0] rt);
      @(posedge smb_clk);
      power_down_pin_n <= pin;
      route_sel <= rt;
      // let the pin cross before any enable is judged
      repeat (8) @(posedge clk_sys);
   endtask

   ////////////////////////////////////////////////////////////////////////////////
   // main sequence
   initial begin
      repeat (5) @(posedge clk_sys);
      rst <= 1'b0;
      rd_chk(8'h03, 8'h0f);
      rd_chk(8'h04, 8'h00);
      exp_en(1'b0, 4'h0, 4'h0);
      drive(1'b1, 8'h00);
      exp_en(1'b1, 4'hf, 4'h1);
      drive(1'b1, 8'he4);
      exp_en(1'b1, 4'hf, 4'hf);
      drive(1'b1, 8'h55);
      exp_en(1'b1, 4'hf, 4'h2);
      drive(1'b1, 8'he4);
      host.wr(8'h03, 8'h0c);
      exp_en(1'b1, 4'hc, 4'hc);
      host.wr(8'h04, 8'hff);
      rd_chk(8'h03, 8'h0c);
      host.wr(8'h03, 8'hbc);
      rd_chk(8'h03, 8'hbc);
      drive(1'b0, 8'he4);
      exp_en(1'b1, 4'hc, 4'hc);
      host.wr(8'h03, 8'h0f);
      exp_en(1'b0, 4'h0, 4'h0);
      host.wr(8'h03, 8'h4f);
      exp_en(1'b0, 4'h0, 4'hf);
      @(posedge clk_sys);
      input_signal_valid <= 4'ha;
      repeat (10) @(posedge clk_sys);
      rd_chk(8'h04, 8'h0a);
      rd_chk(8'h05, 8'h00);
      drive(1'b1, 8'h00);
      exp_en(1'b1, 4'hf, 4'hf);
      host.wr(8'h03, 8'h80);
      exp_en(1'b1, 4'h0, 4'h0);
      end_sim();
   end
endmodule
